// ===== common/dcu_pkg.sv
// Constants, types and lookup data shared by the synthesizer control core.
// Assumes the system clock drives the core and the serial clock drives the port logic.
package dcu_pkg;

    localparam int ACC_W = 32;
    localparam int DAC_W = 14;
    localparam int COS_W = 13;
    localparam int NUM_PROFILES = 4;
    localparam int PROF_W = 2;
    localparam int ADDR_W = 5;
    localparam int WORD_W = 32;
    localparam int CTRL_TWO_W = 24;
    localparam int BIT_CNT_W = 6;
    localparam int LAT_W = 5;

    // Serial address map
    localparam logic [ADDR_W-1:0] ADDR_CTRL_ONE = 5'h00;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_TWO = 5'h01;
    localparam logic [ADDR_W-1:0] ADDR_TUNING_BASE = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_TUNING_LAST = 5'h0A;

    // Serial framing
    localparam logic [BIT_CNT_W-1:0] INSTR_LAST_BIT = 6'h07;
    localparam logic [BIT_CNT_W-1:0] WORD_LAST_BIT_FULL = 6'h1F;
    localparam logic [BIT_CNT_W-1:0] WORD_LAST_BIT_TWO = 6'h17;
    localparam int INSTR_READ_BIT = 7;

    // Field positions, control_reg_one
    localparam int BIT_CLK_PD = 4;
    localparam int BIT_SDIO_IN_ONLY = 9;
    localparam int BIT_CLR_PHASE = 10;
    localparam int BIT_AUTO_SYNC = 23;
    localparam int BIT_OSK_EN = 25;
    // Field positions, control_reg_two
    localparam int MULT_LSB = 3;
    localparam int MULT_MSB = 7;
    localparam int BIT_XTAL_OUT = 9;

    // Reset values
    localparam logic [WORD_W-1:0] CTRL_ONE_BUF_RST = 32'h0000_0000;
    localparam logic [WORD_W-1:0] CTRL_ONE_ACT_RST = 32'h0000_0400;
    localparam logic [CTRL_TWO_W-1:0] CTRL_TWO_RST = 24'h18_0000;
    localparam logic [WORD_W-1:0] TUNING_RST = 32'h0000_0000;

    // Multiplier range that keeps the PLL in use
    localparam logic [4:0] MULT_MIN = 5'h04;
    localparam logic [4:0] MULT_MAX = 5'h14;

    // Sync clock divider (system clock / 4)
    localparam logic [1:0] SYNC_RISE_PHASE = 2'h2;
    localparam logic [1:0] SYNC_ALIGN_LOAD = 2'h1;
    localparam logic [1:0] SYNC_DIV_STEP = 2'h1;

    // Update to new tuning word, in system clock cycles
    localparam logic [LAT_W-1:0] TUNING_LATENCY = 5'h18;
    localparam logic [LAT_W-1:0] LAT_ONE = 5'h01;

    // Quarter-wave cosine, 16 steps
    localparam logic [COS_W-1:0] COS_TAB [16] = '{
        13'h1FFF, 13'h1FD8, 13'h1F62, 13'h1E9E, 13'h1D90, 13'h1C38, 13'h1A9B, 13'h18BC,
        13'h16A0, 13'h144C, 13'h11C7, 13'h0F15, 13'h0C3F, 13'h094A, 13'h063E, 13'h0323
    };

    typedef enum logic [0:0] {
        SER_INSTR = 1'b0,
        SER_DATA = 1'b1
    } dcu_ser_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } dcu_wr_word_t;

    typedef struct packed {
        logic hw_reset;
        logic update;
        logic [PROF_W-1:0] profile;
        logic keying;
        logic sync_in;
        logic osc_select;
        logic wr_toggle;
    } dcu_pins_t;

    typedef struct packed {
        logic pll_enable;
        logic [4:0] pll_mult;
        logic osc_enable;
        logic sys_clock_enable;
        logic crystal_out_enable;
    } dcu_clk_ctrl_t;

endpackage

// ===== dv/dcu_dds_ctrl_sva.sv
// Checker for the synthesizer control core, bound to its ports.
// Assumes the crystal pin changes slowly; realignment pauses the period check.
`timescale 1ns/1ps
module dcu_dds_ctrl_chk
    import dcu_pkg::*;
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic hw_reset_i,
    input wire logic sync_in_i,
    input wire logic oscillator_select_i,
    input wire logic chip_select_n_i,
    input wire logic serial_port_abort_i,
    input wire logic serial_data_oe_o,
    input wire logic serial_read_out_o,
    input wire logic sync_clk_o,
    input wire dcu_clk_ctrl_t clk_ctrl_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rstn_i);
    sequence rst_held;
        hw_reset_i [*6];
    endsequence
    sequence quiet;
        !serial_data_oe_o && !serial_read_out_o;
    endsequence
    sync_period_a: assert property (disable iff (!rstn_i || hw_reset_i || sync_in_i)
        $rose(sync_clk_o) |-> ##4 $rose(sync_clk_o)) else $error("sync clock period wrong");
    desel_quiet_a: assert property (chip_select_n_i && $past(chip_select_n_i) |-> quiet)
        else $error("serial output while deselected");
    abort_quiet_a: assert property (serial_port_abort_i && $past(serial_port_abort_i)
        |-> quiet) else $error("serial output during abort");
    wire_mode_a: assert property (serial_data_oe_o |-> !serial_read_out_o)
        else $error("both read pins active");
    pll_range_a: assert property (clk_ctrl_o.pll_enable ==
        (clk_ctrl_o.pll_mult inside {[MULT_MIN:MULT_MAX]})) else $error("pll enable wrong");
    osc_on_a: assert property ($rose(oscillator_select_i) |->
        ##[1:4] clk_ctrl_o.osc_enable) else $error("oscillator not enabled");
    xtal_gate_a: assert property (clk_ctrl_o.crystal_out_enable |-> clk_ctrl_o.osc_enable)
        else $error("crystal out without oscillator");
    hw_reset_a: assert property (rst_held |-> !clk_ctrl_o.pll_enable
        && clk_ctrl_o.pll_mult == 5'h00 && clk_ctrl_o.sys_clock_enable
        && !clk_ctrl_o.crystal_out_enable) else $error("clock control not reset");
endmodule

// ===== dv/dcu_host_model.sv
// Host side of the serial port: select, serial clock, data pin, abort.
// Assumes the bench calls xfer; the serial clock idles low between frames.
`timescale 1ns/1ps
module dcu_host_model (
    input wire logic oe_i,
    input wire logic sdo_i,
    input wire logic rdo_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic abort_o,
    output logic sdio_o
);
    logic hb;
    assign sdio_o = oe_i ? sdo_i : hb;
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        abort_o = 1'b0;
        hb = 1'b0;
    end
    // Released pin toggles so a stale bit never passes for data
    task automatic xfer(input logic [7:0] ins, input logic [31:0] d, input int n,
        input int cut, output logic [31:0] q_io, output logic [31:0] q_out);
        q_io = '0;
        q_out = '0;
        cs_n_o = 1'b0;
        for (int k = 0; k < n + 8; k++) begin
            if (k == cut + 8) abort_o = 1'b1;
            hb = (ins[7] && k > 7) ? ~hb : (k < 8 ? ins[7 - k] : d[n + 7 - k]);
            #80;
            if (k > 7) begin
                q_io[n + 7 - k] = sdio_o;
                q_out[n + 7 - k] = rdo_i;
            end
            sclk_o = 1'b1;
            #80 sclk_o = 1'b0;
        end
        #80 cs_n_o = 1'b1;
        abort_o = 1'b0;
        #80;
    endtask
endmodule

// ===== dv/tb.sv
// Bench for the synthesizer control core with the host model on its port.
// Assumes the checker module is compiled alongside.
`timescale 1ns/1ps
module tb;
    import dcu_pkg::*;
    logic clk, rstn, hwr, upd, key, osc, sclk, csn, abt, sdi, serial_read_out, oe, rdo, syncc, ramp, syi;
    logic [1:0] prof;
    logic [13:0] dac, d0;
    logic [4:0] ms [4] = '{5'h03, 5'h14, 5'h15, 5'h04};
    dcu_clk_ctrl_t cc;
    logic [31:0] q_io, q_out;
    int mismatches, n_tests, cyc;
    // 1 ms of 25 ns cycles for the PLL to settle
    localparam int PLL_LOCK_CYC = 40000;
    dcu_dds_ctrl dut (.clock_i(clk), .rstn_i(rstn), .hw_reset_i(hwr), .update_i(upd),
        .profile_select_i(prof), .keying_direction_in_i(key), .sync_in_i(syi),
        .oscillator_select_i(osc), .serial_clk_i(sclk), .chip_select_n_i(csn),
        .serial_data_i(sdi), .serial_port_abort_i(abt), .serial_data_o(serial_read_out),
        .serial_data_oe_o(oe), .serial_read_out_o(rdo), .sync_clk_o(syncc),
        .dac_sample_o(dac), .ramp_dir_o(ramp), .clk_ctrl_o(cc));
    dcu_host_model host (.oe_i(oe), .sdo_i(serial_read_out), .rdo_i(rdo), .sclk_o(sclk),
        .cs_n_o(csn), .abort_o(abt), .sdio_o(sdi));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            mismatches++;
            stop_test;
        end
    end
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        host.xfer({3'h0, a}, d, (a == ADDR_CTRL_TWO) ? 24 : 32, 99, q_io, q_out);
    endtask
    task automatic rd(input logic [4:0] a);
        host.xfer({3'h4, a}, 32'h0, 32, 99, q_io, q_out);
    endtask
    // Strobe moves just after a sync clock rise, held two sync periods
    task automatic pulse;
        @(posedge syncc);
        #2 upd = 1'b1;
        tk(8);
        upd = 1'b0;
    endtask
    task automatic t_serial;
        chk("clk_ctrl", 32'(cc), 32'h002);
        wr(ADDR_TUNING_BASE, 32'h1000_0000);
        rd(ADDR_TUNING_BASE);
        chk("sdio read", q_io, 32'h1000_0000);
        chk("read out idle", q_out, 32'h0);
        wr(5'h03, 32'hFFFF_FFFF);
        rd(5'h03);
        chk("unmapped", q_io, 32'h0);
        host.xfer({3'h0, ADDR_TUNING_BASE}, 32'h5555_AAAA, 32, 12, q_io, q_out);
        rd(ADDR_TUNING_BASE);
        chk("after abort", q_io, 32'h1000_0000);
        wr(ADDR_CTRL_ONE, 32'h0000_0200);
        rd(ADDR_TUNING_BASE);
        chk("three wire", q_out, 32'h1000_0000);
        chk("cleared dac", 32'(dac), 32'h1FFF);
    endtask
    task automatic t_update;
        pulse;
        tk(21);
        chk("dac early", 32'(dac), 32'h1FFF);
        tk(15);
        d0 = dac;
        tk(8);
        chk("half turn", 32'(dac), 32'(14'(-d0)));
        tk(8);
        chk("full turn", 32'(dac), 32'(d0));
        wr(ADDR_TUNING_BASE, 32'h0);
        pulse;
        tk(40);
        d0 = dac;
        tk(13);
        chk("frozen", 32'(dac), 32'(d0));
        wr(ADDR_CTRL_ONE, 32'h0000_0600);
        pulse;
        tk(10);
        chk("clear phase", 32'(dac), 32'h1FFF);
    endtask
    task automatic t_profile;
        wr(ADDR_CTRL_ONE, 32'h0000_0200);
        wr(5'h06, 32'h4000_0000);
        @(posedge syncc);
        #2 prof = 2'h1;
        tk(40);
        d0 = dac;
        tk(2);
        chk("profile one", 32'(dac), 32'(14'(-d0)));
        wr(5'h06, 32'h1000_0000);
        d0 = dac;
        tk(2);
        chk("profile kept", 32'(dac), 32'(14'(-d0)));
    endtask
    task automatic t_clock;
        osc = 1'b1;
        tk(6);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CTRL_TWO, (32'(ms[i]) << 3) | 32'h200);
            pulse;
            tk(4);
            chk("pll", {cc.pll_enable, cc.pll_mult, cc.crystal_out_enable},
                {ms[i] >= 5'h04 && ms[i] <= 5'h14, ms[i], 1'b1});
        end
        // Output is only trusted once the PLL has had time to lock
        tk(PLL_LOCK_CYC);
        wr(ADDR_CTRL_ONE, 32'h0200_0210);
        pulse;
        tk(4);
        chk("power down", {cc.sys_clock_enable, cc.pll_enable, cc.osc_enable}, 3'b011);
        d0 = dac;
        tk(5);
        chk("stopped", 32'(dac), 32'(d0));
        @(posedge syncc);
        #2 key = 1'b1;
        tk(12);
        chk("ramp up", 32'(ramp), 32'h1);
        key = 1'b0;
        tk(12);
        chk("ramp down", 32'(ramp), 32'h0);
        osc = 1'b0;
        tk(6);
        chk("osc off", {cc.osc_enable, cc.crystal_out_enable}, 2'b00);
    endtask
    // Sync raised one cycle past a sync rise, so realignment visibly shifts the phase
    task automatic t_sync;
        wr(ADDR_CTRL_ONE, 32'h0080_0200);
        pulse;
        tk(4);
        @(posedge syncc);
        tk(1);
        syi = 1'b1;
        tk(3);
        chk("sync aligned", 32'(syncc), 32'h0);
        tk(1);
        chk("sync rise", 32'(syncc), 32'h1);
        syi = 1'b0;
        tk(8);
    endtask
    task automatic t_hwreset;
        hwr = 1'b1;
        tk(6);
        hwr = 1'b0;
        tk(6);
        chk("reset ctrl", 32'(cc), 32'h002);
        chk("reset dac", 32'(dac), 32'h1FFF);
        rd(ADDR_TUNING_BASE);
        chk("reset word", q_io, 32'h0);
    endtask
    initial begin
        {rstn, hwr, upd, key, osc, syi, prof, cyc, mismatches, n_tests} = '0;
        tk(3);
        rstn = 1'b1;
        tk(4);
        t_serial;
        t_update;
        t_profile;
        t_clock;
        t_sync;
        t_hwreset;
        stop_test;
    end
endmodule
bind dcu_dds_ctrl dcu_dds_ctrl_chk chk_i (.clock_i, .rstn_i, .hw_reset_i, .sync_in_i,
    .oscillator_select_i, .chip_select_n_i, .serial_port_abort_i, .serial_data_oe_o,
    .serial_read_out_o, .sync_clk_o, .clk_ctrl_o);

// ===== rtl/dcu_dds_ctrl.sv
// Synthesizer control core: serial port, buffered/active registers, update logic,
// phase accumulator with cosine lookup, sync clock and clock source control.
// Assumes clock_i is the system clock; serial_clk_i is the host's serial clock.
`timescale 1ns/1ps
module dcu_dds_ctrl
    import dcu_pkg::*;
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic hw_reset_i,
    input wire logic update_i,
    input wire logic [PROF_W-1:0] profile_select_i,
    input wire logic keying_direction_in_i,
    input wire logic sync_in_i,
    input wire logic oscillator_select_i,
    input wire logic serial_clk_i,
    input wire logic chip_select_n_i,
    input wire logic serial_data_i,
    input wire logic serial_port_abort_i,
    output logic serial_data_o,
    output logic serial_data_oe_o,
    output logic serial_read_out_o,
    output logic sync_clk_o,
    output logic [DAC_W-1:0] dac_sample_o,
    output logic ramp_dir_o,
    output dcu_clk_ctrl_t clk_ctrl_o
);

    function automatic logic tuning_hit(input logic [ADDR_W-1:0] a);
        tuning_hit = (a >= ADDR_TUNING_BASE) && (a <= ADDR_TUNING_LAST) && !a[0];
    endfunction

    function automatic logic [PROF_W-1:0] tuning_idx(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = a - ADDR_TUNING_BASE;
        tuning_idx = off[PROF_W:1];
    endfunction

    // ---------------- Serial clock domain ----------------
    // Port state clears while deselected, aborted or in reset; no sclk edge needed.
    wire spi_rst_n = rstn_i & ~serial_port_abort_i & ~chip_select_n_i & ~hw_reset_i;
    wire mir_rst_n = rstn_i & ~hw_reset_i;

    dcu_ser_state_t ser_state_reg;
    dcu_ser_state_t ser_state_next;
    logic [BIT_CNT_W-1:0] bit_cnt_reg;
    logic [BIT_CNT_W-1:0] bit_cnt_next;
    logic [WORD_W-1:0] shift_reg;
    logic [7:0] instr_reg;
    logic [WORD_W-1:0] rd_word_reg;
    logic [WORD_W-1:0] mir_one_reg;
    logic [CTRL_TWO_W-1:0] mir_two_reg;
    logic [WORD_W-1:0] mir_tuning_reg [NUM_PROFILES];
    dcu_wr_word_t wr_word_reg;
    logic wr_toggle_reg;
    logic sdo_reg;
    logic sdio_out_reg;
    logic sdio_oe_reg;

    wire [WORD_W-1:0] shift_next = {shift_reg[WORD_W-2:0], serial_data_i};
    wire [ADDR_W-1:0] new_addr = shift_next[ADDR_W-1:0];
    wire [ADDR_W-1:0] cur_addr = instr_reg[ADDR_W-1:0];
    wire cur_read = instr_reg[INSTR_READ_BIT];
    wire [BIT_CNT_W-1:0] word_last =
        (cur_addr == ADDR_CTRL_TWO) ? WORD_LAST_BIT_TWO : WORD_LAST_BIT_FULL;
    wire instr_done = (ser_state_reg == SER_INSTR) && (bit_cnt_reg == INSTR_LAST_BIT);
    wire word_done = (ser_state_reg == SER_DATA) && (bit_cnt_reg == word_last);
    wire commit = word_done && !cur_read;
    wire three_wire = mir_one_reg[BIT_SDIO_IN_ONLY];
    wire reading = (ser_state_reg == SER_DATA) && cur_read;
    wire [BIT_CNT_W-1:0] out_idx = word_last - bit_cnt_reg;
    wire out_bit = rd_word_reg[out_idx[ADDR_W-1:0]];
    wire [WORD_W-1:0] rd_lookup =
        (new_addr == ADDR_CTRL_ONE) ? mir_one_reg :
        (new_addr == ADDR_CTRL_TWO) ? WORD_W'(mir_two_reg) :
        tuning_hit(new_addr) ? mir_tuning_reg[tuning_idx(new_addr)] : '0;

    always_comb begin
        ser_state_next = ser_state_reg;
        bit_cnt_next = bit_cnt_reg + 6'h01;
        if (instr_done) begin
            ser_state_next = SER_DATA;
            bit_cnt_next = '0;
        end else if (word_done) begin
            ser_state_next = SER_INSTR;
            bit_cnt_next = '0;
        end
    end

    always_ff @(posedge serial_clk_i or negedge spi_rst_n) begin
        if (!spi_rst_n) begin
            ser_state_reg <= SER_INSTR;
            bit_cnt_reg <= '0;
            shift_reg <= '0;
            instr_reg <= '0;
            rd_word_reg <= '0;
        end else begin
            ser_state_reg <= ser_state_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            instr_reg <= instr_done ? shift_next[7:0] : instr_reg;
            rd_word_reg <= instr_done ? rd_lookup : rd_word_reg;
        end
    end

    // Read-back copy of the buffers, kept in this domain so reads need no crossing
    always_ff @(posedge serial_clk_i or negedge mir_rst_n) begin
        if (!mir_rst_n) begin
            mir_one_reg <= CTRL_ONE_BUF_RST;
            mir_two_reg <= CTRL_TWO_RST;
        end else begin
            if (commit && cur_addr == ADDR_CTRL_ONE) begin
                mir_one_reg <= shift_next;
            end
            if (commit && cur_addr == ADDR_CTRL_TWO) begin
                mir_two_reg <= shift_next[CTRL_TWO_W-1:0];
            end
        end
    end

    // Word handed to the core; abort must not flip the toggle or a bogus write appears
    always_ff @(posedge serial_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_word_reg <= '0;
            wr_toggle_reg <= 1'b0;
        end else if (commit && spi_rst_n) begin
            wr_word_reg <= '{addr: cur_addr, data: shift_next};
            wr_toggle_reg <= ~wr_toggle_reg;
        end
    end

    // Output data changes on the falling serial clock edge
    always_ff @(negedge serial_clk_i or negedge spi_rst_n) begin
        if (!spi_rst_n) begin
            sdo_reg <= 1'b0;
            sdio_out_reg <= 1'b0;
            sdio_oe_reg <= 1'b0;
        end else begin
            sdo_reg <= reading && three_wire && out_bit;
            sdio_out_reg <= reading && !three_wire && out_bit;
            sdio_oe_reg <= reading && !three_wire;
        end
    end

    assign serial_read_out_o = sdo_reg;
    assign serial_data_o = sdio_out_reg;
    assign serial_data_oe_o = sdio_oe_reg;

    // ---------------- System clock domain ----------------
    dcu_pins_t pins_raw;
    dcu_pins_t pins_s1_reg;
    dcu_pins_t pins_s2_reg;

    assign pins_raw = '{hw_reset: hw_reset_i, update: update_i, profile: profile_select_i,
                        keying: keying_direction_in_i, sync_in: sync_in_i,
                        osc_select: oscillator_select_i, wr_toggle: wr_toggle_reg};

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pins_s1_reg <= '0;
            pins_s2_reg <= '0;
        end else begin
            pins_s1_reg <= pins_raw;
            pins_s2_reg <= pins_s1_reg;
        end
    end

    logic soft_rst;
    assign soft_rst = pins_s2_reg.hw_reset;

    logic tog_seen_reg;
    logic sync_in_prev_reg;
    logic [1:0] div_reg;
    logic sync_clk_reg;
    logic upd_prev_reg;
    logic [PROF_W-1:0] prof_prev_reg;
    logic ramp_dir_reg;
    logic [WORD_W-1:0] buf_one_reg;
    logic [CTRL_TWO_W-1:0] buf_two_reg;
    logic [WORD_W-1:0] buf_tuning_reg [NUM_PROFILES];
    logic [WORD_W-1:0] act_one_reg;
    logic [CTRL_TWO_W-1:0] act_two_reg;
    logic [WORD_W-1:0] act_tuning_reg;
    logic [LAT_W-1:0] lat_cnt_reg;
    logic [WORD_W-1:0] live_tuning_reg;
    logic [ACC_W-1:0] acc_reg;
    logic [DAC_W-1:0] dac_reg;
    dcu_clk_ctrl_t clk_ctrl_reg;

    // Sync clock divider and slave alignment
    wire sync_edge = pins_s2_reg.sync_in && !sync_in_prev_reg && act_one_reg[BIT_AUTO_SYNC];
    wire [1:0] div_next = sync_edge ? SYNC_ALIGN_LOAD : div_reg + SYNC_DIV_STEP;
    wire sync_tick = (div_reg == SYNC_RISE_PHASE);

    // Update events, sampled once per sync clock period
    wire upd_evt = sync_tick && pins_s2_reg.update && !upd_prev_reg;
    wire prof_evt = sync_tick && (pins_s2_reg.profile != prof_prev_reg);
    wire xfer = upd_evt || prof_evt;
    wire [PROF_W-1:0] sel_prof = pins_s2_reg.profile;

    wire wr_evt = pins_s2_reg.wr_toggle ^ tog_seen_reg;
    wire [ADDR_W-1:0] wr_addr = wr_word_reg.addr;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tog_seen_reg <= 1'b0;
            sync_in_prev_reg <= 1'b0;
            div_reg <= '0;
            sync_clk_reg <= 1'b0;
        end else begin
            tog_seen_reg <= pins_s2_reg.wr_toggle;
            sync_in_prev_reg <= pins_s2_reg.sync_in;
            div_reg <= div_next;
            sync_clk_reg <= div_next[1];
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            upd_prev_reg <= 1'b0;
            prof_prev_reg <= '0;
            ramp_dir_reg <= 1'b0;
        end else if (soft_rst) begin
            upd_prev_reg <= 1'b0;
            prof_prev_reg <= '0;
            ramp_dir_reg <= 1'b0;
        end else if (sync_tick) begin
            upd_prev_reg <= pins_s2_reg.update;
            prof_prev_reg <= pins_s2_reg.profile;
            ramp_dir_reg <= act_one_reg[BIT_OSK_EN] && pins_s2_reg.keying;
        end
    end

    // Buffered registers, written by the serial port
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            buf_one_reg <= CTRL_ONE_BUF_RST;
            buf_two_reg <= CTRL_TWO_RST;
        end else if (soft_rst) begin
            buf_one_reg <= CTRL_ONE_BUF_RST;
            buf_two_reg <= CTRL_TWO_RST;
        end else begin
            if (wr_evt && wr_addr == ADDR_CTRL_ONE) begin
                buf_one_reg <= wr_word_reg.data;
            end
            if (wr_evt && wr_addr == ADDR_CTRL_TWO) begin
                buf_two_reg <= wr_word_reg.data[CTRL_TWO_W-1:0];
            end
        end
    end

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PROFILES; gp++) begin : g_prof
            wire hit_core = wr_evt && tuning_hit(wr_addr) && (tuning_idx(wr_addr) == gp);
            wire hit_ser = commit && tuning_hit(cur_addr) && (tuning_idx(cur_addr) == gp);

            always_ff @(posedge clock_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    buf_tuning_reg[gp] <= TUNING_RST;
                end else if (soft_rst) begin
                    buf_tuning_reg[gp] <= TUNING_RST;
                end else if (hit_core) begin
                    buf_tuning_reg[gp] <= wr_word_reg.data;
                end
            end

            always_ff @(posedge serial_clk_i or negedge mir_rst_n) begin
                if (!mir_rst_n) begin
                    mir_tuning_reg[gp] <= TUNING_RST;
                end else if (hit_ser) begin
                    mir_tuning_reg[gp] <= shift_next;
                end
            end
        end
    endgenerate

    // Active registers; clear-phase starts set so the phase stays at zero until first update
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            act_one_reg <= CTRL_ONE_ACT_RST;
            act_two_reg <= CTRL_TWO_RST;
            act_tuning_reg <= TUNING_RST;
        end else if (soft_rst) begin
            act_one_reg <= CTRL_ONE_ACT_RST;
            act_two_reg <= CTRL_TWO_RST;
            act_tuning_reg <= TUNING_RST;
        end else if (xfer) begin
            act_one_reg <= buf_one_reg;
            act_two_reg <= buf_two_reg;
            act_tuning_reg <= buf_tuning_reg[sel_prof];
        end
    end

    // Tuning word reaches the accumulator only after the fixed latency
    wire [LAT_W-1:0] lat_next = xfer ? TUNING_LATENCY - LAT_ONE :
        (lat_cnt_reg != '0) ? lat_cnt_reg - LAT_ONE : lat_cnt_reg;
    wire lat_load = (lat_cnt_reg == LAT_ONE) && !xfer;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lat_cnt_reg <= '0;
            live_tuning_reg <= TUNING_RST;
        end else if (soft_rst) begin
            lat_cnt_reg <= '0;
            live_tuning_reg <= TUNING_RST;
        end else begin
            lat_cnt_reg <= lat_next;
            live_tuning_reg <= lat_load ? act_tuning_reg : live_tuning_reg;
        end
    end

    // Phase accumulator; holds while the system clock is powered down, unless clear-phase forces it to zero
    wire clr_phase = act_one_reg[BIT_CLR_PHASE];
    wire clk_stopped = act_one_reg[BIT_CLK_PD];
    wire [ACC_W-1:0] acc_next = clr_phase ? '0 :
        clk_stopped ? acc_reg : acc_reg + live_tuning_reg;

    // Quarter-wave cosine with quadrant folding
    wire [1:0] quad = acc_reg[ACC_W-1 -: 2];
    wire [3:0] idx = acc_reg[ACC_W-3 -: 4];
    wire [3:0] idx_mirror = 4'h0 - idx;
    wire [COS_W-1:0] mag_fwd = COS_TAB[idx];
    wire [COS_W-1:0] mag_rev = (idx == 4'h0) ? '0 : COS_TAB[idx_mirror];
    wire [COS_W-1:0] mag = quad[0] ? mag_rev : mag_fwd;
    wire [DAC_W-1:0] mag_ext = {1'b0, mag};
    wire [DAC_W-1:0] sample = (quad[0] ^ quad[1]) ? DAC_W'(~mag_ext + 14'h0001) : mag_ext;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            acc_reg <= '0;
            dac_reg <= '0;
        end else if (soft_rst) begin
            acc_reg <= '0;
            dac_reg <= '0;
        end else begin
            acc_reg <= acc_next;
            dac_reg <= sample;
        end
    end

    // Clock source control
    wire [4:0] mult = act_two_reg[MULT_MSB:MULT_LSB];
    wire pll_in_range = (mult >= MULT_MIN) && (mult <= MULT_MAX);
    dcu_clk_ctrl_t clk_ctrl_next;
    assign clk_ctrl_next = '{
        pll_enable: pll_in_range,
        pll_mult: mult,
        osc_enable: pins_s2_reg.osc_select,
        sys_clock_enable: !clk_stopped,
        crystal_out_enable: pins_s2_reg.osc_select && act_two_reg[BIT_XTAL_OUT]
    };

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            clk_ctrl_reg <= '0;
        end else begin
            clk_ctrl_reg <= clk_ctrl_next;
        end
    end

    assign sync_clk_o = sync_clk_reg;
    assign dac_sample_o = dac_reg;
    assign ramp_dir_o = ramp_dir_reg;
    assign clk_ctrl_o = clk_ctrl_reg;

endmodule
